// ---- rtl/pcst_top.sv ----
// Purpose: program counter flow, return stack, table read, alu, serial programming
// Assumes: sequencer and interrupt logic run on core_clk_i; programming pins are async
// Notes: one clock edge is one instruction cycle
`include "pcst_params.svh"

module pcst_top #(
  parameter int PMEM_WORDS = `PCST_PMEM_WORDS_DEF,
  parameter int STACK_DEPTH = `PCST_STACK_DEPTH_DEF,
  localparam int AW = $clog2(PMEM_WORDS)
) (
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input pcst_pkg::pcst_cmd_t cmd_i,
  input wire logic int_req_i,
  input wire logic int_en_i,
  input wire logic [15:0] int_vector_i,
  input wire logic [7:0] tblp_i,
  input wire logic [7:0] tbhp_i,
  input wire logic table_high_latch_wr_i,
  input wire logic [7:0] table_high_latch_wdata_i,
  input pcst_pkg::pcst_alu_req_t alu_req_i,
  input wire logic prog_mode_i,
  input wire logic prog_serial_clock_i,
  input wire logic prog_serial_data_i,
  output logic [AW-1:0] pc_o,
  output logic [15:0] instr_o,
  output logic ready_o,
  output logic int_ack_o,
  output pcst_pkg::pcst_dwr_t dwr_o,
  output logic [7:0] table_high_latch_o,
  output pcst_pkg::pcst_alu_res_t alu_res_o,
  output logic prog_serial_data_o,
  output logic prog_serial_data_oe_n_o
);
  import pcst_pkg::*;

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync;
  logic rst_n;

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // ----------------------------------------------------------------
  // program memory, 16-bit words addressed by the pc
  // ----------------------------------------------------------------
  logic [`PCST_WORD_BITS-1:0] pmem [PMEM_WORDS];
  logic pm_we;
  logic [AW-1:0] pm_waddr;
  logic [15:0] pm_wdata;

  always_ff @(posedge core_clk_i) begin
    if (pm_we) begin
      pmem[pm_waddr] <= pm_wdata;
    end
  end

  // ----------------------------------------------------------------
  // return stack
  // ----------------------------------------------------------------
  logic push;
  logic pop;
  logic [AW-1:0] push_data;
  logic [AW-1:0] stk_top;
  logic stk_full;

  pcst_ret_stack #(
    .DEPTH(STACK_DEPTH),
    .W(AW)
  ) u_stack (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n),
    .push_i(push),
    .pop_i(pop),
    .push_data_i(push_data),
    .top_o(stk_top),
    .full_o(stk_full)
  );

  // ----------------------------------------------------------------
  // flow control
  // ----------------------------------------------------------------
  pcst_state_t state;
  pcst_state_t next_state;
  logic [AW-1:0] next_pc;
  logic [15:0] next_instr;
  logic int_pend;
  logic next_int_pend;
  logic next_int_ack;
  logic [15:0] tbl_word;
  logic [15:0] next_tbl_word;
  logic [15:0] tbl_dest;
  logic [15:0] next_tbl_dest;
  logic [7:0] next_table_high_latch;
  pcst_dwr_t next_dwr;
  logic [AW-1:0] tbl_addr;
  logic [AW-1:0] tbl_last_addr;

  // full pointer pair, or the last page with the low pointer
  assign tbl_addr = AW'({tbhp_i, tblp_i});
  assign tbl_last_addr = {{(AW - `PCST_BYTE_BITS){1'b1}}, tblp_i};

  always_comb begin
    next_state = state;
    next_pc = pc_o;
    push = 1'b0;
    pop = 1'b0;
    push_data = pc_o;
    next_int_pend = int_pend | int_req_i;
    next_int_ack = 1'b0;
    next_tbl_word = tbl_word;
    next_tbl_dest = tbl_dest;
    next_table_high_latch = table_high_latch_o;
    next_dwr = '0;
    if (table_high_latch_wr_i) begin
      next_table_high_latch = table_high_latch_wdata_i;
    end
    case (state)
      st_run: begin
        case (cmd_i.op)
          op_none: begin
            // request stays latched while the stack is full
            if (int_pend && int_en_i && !stk_full) begin
              push = 1'b1;
              push_data = pc_o;
              next_pc = int_vector_i[AW-1:0];
              next_int_pend = int_req_i;
              next_int_ack = 1'b1;
              next_state = st_refetch;
            end
          end
          op_seq: begin
            next_pc = pc_o + 1'b1;
          end
          op_jump: begin
            next_pc = cmd_i.target[AW-1:0];
            next_state = st_refetch;
          end
          op_call: begin
            // allowed even when full; the oldest entry is overwritten
            push = 1'b1;
            push_data = pc_o + 1'b1;
            next_pc = cmd_i.target[AW-1:0];
            next_state = st_refetch;
          end
          subroutine_return_op,
          interrupt_return_op: begin
            pop = 1'b1;
            next_pc = stk_top;
            next_state = st_refetch;
          end
          op_pcl_write: begin
            next_pc = {pc_o[AW-1:`PCST_BYTE_BITS], cmd_i.pcl_data};
            next_state = st_refetch;
          end
          op_table_read,
          table_read_lastpage_op: begin
            next_tbl_word = (cmd_i.op == op_table_read) ? pmem[tbl_addr] : pmem[tbl_last_addr];
            next_tbl_dest = {`PCST_SHORT_SECTOR, cmd_i.dest_addr};
            next_pc = pc_o + 1'b1;
            next_state = st_table;
          end
          long_table_read_op,
          long_table_read_lastpage_op: begin
            next_tbl_word = (cmd_i.op == long_table_read_op) ? pmem[tbl_addr] :
                            pmem[tbl_last_addr];
            next_tbl_dest = {cmd_i.dest_sector, cmd_i.dest_addr};
            next_pc = pc_o + 1'b1;
            next_state = st_table;
          end
          default: begin
            next_pc = pc_o;
          end
        endcase
      end
      st_table: begin
        // second cycle of the table read splits the word
        next_dwr.wr = 1'b1;
        next_dwr.sector = tbl_dest[15:8];
        next_dwr.addr = tbl_dest[7:0];
        next_dwr.data = tbl_word[7:0];
        next_table_high_latch = tbl_word[15:8];
        next_state = st_run;
      end
      default: begin
        next_state = st_run;
      end
    endcase
    next_instr = pmem[next_pc];
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state <= st_refetch; // first cycle fetches the reset vector
      pc_o <= AW'(`PCST_RESET_VECTOR);
      instr_o <= '0;
      ready_o <= 1'b0;
      int_pend <= 1'b0;
      int_ack_o <= 1'b0;
      tbl_word <= '0;
      tbl_dest <= '0;
      table_high_latch_o <= '0;
      dwr_o <= '0;
    end else begin
      state <= next_state;
      pc_o <= next_pc;
      instr_o <= next_instr;
      ready_o <= (next_state == st_run);
      int_pend <= next_int_pend;
      int_ack_o <= next_int_ack;
      tbl_word <= next_tbl_word;
      tbl_dest <= next_tbl_dest;
      table_high_latch_o <= next_table_high_latch;
      dwr_o <= next_dwr;
    end
  end

  // ----------------------------------------------------------------
  // alu
  // ----------------------------------------------------------------
  function automatic pcst_alu_res_t alu_calc(input pcst_alu_req_t r);
    logic [8:0] s;
    logic [4:0] h;
    logic [7:0] bb;
    logic ci;
    logic arith;
    pcst_alu_res_t o;
    s = '0;
    h = '0;
    bb = (r.op == alu_sub || r.op == alu_sbc) ? ~r.b : r.b;
    ci = 1'b0;
    arith = 1'b1;
    o = '0;
    case (r.op)
      alu_adc: ci = r.cin;
      alu_sub: ci = 1'b1;
      alu_sbc: ci = r.cin;
      alu_and: arith = 1'b0;
      alu_or: arith = 1'b0;
      alu_xor: arith = 1'b0;
      alu_cpl: arith = 1'b0;
      default: ci = 1'b0;
    endcase
    s = {1'b0, r.a} + {1'b0, bb} + {8'h00, ci};
    h = {1'b0, r.a[3:0]} + {1'b0, bb[3:0]} + {4'h0, ci};
    case (r.op)
      alu_and: s[7:0] = r.a & r.b;
      alu_or: s[7:0] = r.a | r.b;
      alu_xor: s[7:0] = r.a ^ r.b;
      alu_cpl: s[7:0] = ~r.a;
      default: s[7:0] = s[7:0];
    endcase
    o.valid = r.valid;
    o.to_mem = r.to_mem;
    o.dest_addr = r.dest_addr;
    o.data = s[7:0];
    o.z = (s[7:0] == 8'h00);
    // logic operations leave carry, half carry and overflow alone
    o.c = arith ? s[8] : r.cin;
    o.ac = arith ? h[4] : r.acin;
    o.ov = arith ? ((r.a[7] == bb[7]) && (s[7] != r.a[7])) : r.ovin;
    return o;
  endfunction

  pcst_alu_res_t next_alu_res;

  always_comb begin
    next_alu_res = alu_calc(alu_req_i);
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      alu_res_o <= '0;
    end else begin
      alu_res_o <= next_alu_res;
    end
  end

  // ----------------------------------------------------------------
  // serial programming port
  // ----------------------------------------------------------------
  // pins are async: two stages, then a third copy of the clock for edges
  logic [2:0] psync1;
  logic [2:0] psync2;
  logic psck_d;
  logic [4:0] pcnt;
  logic [4:0] next_pcnt;
  logic pwr;
  logic next_pwr;
  logic [12:0] paddr;
  logic [12:0] next_paddr;
  logic [15:0] psh;
  logic [15:0] next_psh;
  logic next_pdout;
  logic next_poe_n;
  logic prise;

  assign prise = psync2[1] & ~psck_d;

  always_comb begin
    next_pcnt = pcnt;
    next_pwr = pwr;
    next_paddr = paddr;
    next_psh = psh;
    next_pdout = prog_serial_data_o;
    next_poe_n = prog_serial_data_oe_n_o;
    pm_we = 1'b0;
    pm_waddr = paddr[AW-1:0];
    pm_wdata = {psh[14:0], psync2[0]};
    if (!psync2[2]) begin
      next_pcnt = '0;
      next_poe_n = 1'b1;
    end else if (prise && pcnt <= `PCST_PROG_FRAME_LAST) begin
      next_pcnt = pcnt + 1'b1;
      if (pcnt == `PCST_PROG_CMD_BIT) begin
        next_pwr = psync2[0];
      end else if (pcnt <= `PCST_PROG_ADDR_LAST) begin
        next_paddr = {paddr[11:0], psync2[0]};
        if (pcnt == `PCST_PROG_ADDR_LAST && !pwr) begin
          // read: the line turns round and the word goes out msb first
          next_psh = pmem[next_paddr[AW-1:0]];
          next_pdout = next_psh[15];
          next_poe_n = 1'b0;
        end
      end else if (pwr) begin
        next_psh = {psh[14:0], psync2[0]};
        pm_we = (pcnt == `PCST_PROG_FRAME_LAST);
      end else begin
        next_psh = {psh[14:0], 1'b0};
        next_pdout = psh[14];
        next_poe_n = (pcnt == `PCST_PROG_FRAME_LAST);
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      psync1 <= '0;
      psync2 <= '0;
      psck_d <= 1'b0;
      pcnt <= '0;
      pwr <= 1'b0;
      paddr <= '0;
      psh <= '0;
      prog_serial_data_o <= 1'b0;
      prog_serial_data_oe_n_o <= 1'b1;
    end else begin
      psync1 <= {prog_mode_i, prog_serial_clock_i, prog_serial_data_i};
      psync2 <= psync1;
      psck_d <= psync2[1];
      pcnt <= next_pcnt;
      pwr <= next_pwr;
      paddr <= next_paddr;
      psh <= next_psh;
      prog_serial_data_o <= next_pdout;
      prog_serial_data_oe_n_o <= next_poe_n;
    end
  end
endmodule

// ---- rtl/pcst_params.svh ----
// Purpose: constants for the program-flow and table-read block
// Assumes: included by the package and the design files by bare name
// Notes: definitions only
`ifndef PCST_PARAMS_SVH
`define PCST_PARAMS_SVH

// ----------------------------------------------------------------
// sizes
// ----------------------------------------------------------------
`define PCST_PMEM_WORDS_DEF 8192
`define PCST_STACK_DEPTH_DEF 8
`define PCST_WORD_BITS 16
`define PCST_BYTE_BITS 8

// ----------------------------------------------------------------
// vectors and sectors
// ----------------------------------------------------------------
`define PCST_RESET_VECTOR 16'h0000
`define PCST_SHORT_SECTOR 8'h00

// ----------------------------------------------------------------
// serial programming frame: 1 command bit, 13 address bits, 16 data bits
// ----------------------------------------------------------------
`define PCST_PROG_ADDR_BITS 13
`define PCST_PROG_CMD_BIT 5'h00
`define PCST_PROG_ADDR_LAST 5'h0d
`define PCST_PROG_FRAME_LAST 5'h1d

`endif

// ---- rtl/pcst_pkg.sv ----
// Purpose: types shared by the program-flow and table-read block
// Assumes: pcst_params.svh holds the numbers
// Notes: commands arrive from the instruction sequencer on the same clock
`include "pcst_params.svh"

package pcst_pkg;

  // ----------------------------------------------------------------
  // sequencer commands
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    op_none = 4'h0,
    op_seq = 4'h1,
    op_jump = 4'h2,
    op_call = 4'h3,
    subroutine_return_op = 4'h4,
    interrupt_return_op = 4'h5,
    op_pcl_write = 4'h6,
    op_table_read = 4'h7,
    table_read_lastpage_op = 4'h8,
    long_table_read_op = 4'h9,
    long_table_read_lastpage_op = 4'ha
  } pcst_op_t;

  typedef struct packed {
    pcst_op_t op;
    logic [15:0] target;
    logic [7:0] pcl_data;
    logic [7:0] dest_sector;
    logic [7:0] dest_addr;
  } pcst_cmd_t;

  // data memory write produced by a table read
  typedef struct packed {
    logic wr;
    logic [7:0] sector;
    logic [7:0] addr;
    logic [7:0] data;
  } pcst_dwr_t;

  // ----------------------------------------------------------------
  // alu
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    alu_add = 3'h0,
    alu_adc = 3'h1,
    alu_sub = 3'h2,
    alu_sbc = 3'h3,
    alu_and = 3'h4,
    alu_or = 3'h5,
    alu_xor = 3'h6,
    alu_cpl = 3'h7
  } pcst_alu_op_t;

  typedef struct packed {
    logic valid;
    pcst_alu_op_t op;
    logic [7:0] a;
    logic [7:0] b;
    logic cin;
    logic acin;
    logic ovin;
    logic to_mem;
    logic [7:0] dest_addr;
  } pcst_alu_req_t;

  typedef struct packed {
    logic valid;
    logic to_mem;
    logic [7:0] dest_addr;
    logic [7:0] data;
    logic c;
    logic ac;
    logic z;
    logic ov;
  } pcst_alu_res_t;

  // ----------------------------------------------------------------
  // flow states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    st_run = 3'b001,
    st_refetch = 3'b010,
    st_table = 3'b100
  } pcst_state_t;

endpackage

// ---- rtl/pcst_ret_stack.sv ----
// Purpose: hidden return-address stack, circular so overflow drops the oldest
// Assumes: push and pop never requested together; push wins if they are
// Notes: ports expose only the top entry and a full flag, not the level count
`include "pcst_params.svh"

module pcst_ret_stack #(
  parameter int DEPTH = `PCST_STACK_DEPTH_DEF,
  parameter int W = 13
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic push_i,
  input wire logic pop_i,
  input wire logic [W-1:0] push_data_i,
  output logic [W-1:0] top_o,
  output logic full_o
);
  import pcst_pkg::*;

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
  localparam logic [PW:0] CNT_FULL = (PW + 1)'(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [PW-1:0] ptr;
  logic [PW:0] count;
  logic [PW-1:0] next_ptr;
  logic [PW:0] next_count;
  logic [PW-1:0] top_idx;

  // ----------------------------------------------------------------
  // pointer logic
  // ----------------------------------------------------------------
  always_comb begin
    next_ptr = ptr;
    next_count = count;
    top_idx = (ptr == '0) ? LAST : ptr - 1'b1;
    if (push_i) begin
      next_ptr = (ptr == LAST) ? '0 : ptr + 1'b1;
      // a push when full overwrites the oldest slot, level stays full
      if (count != CNT_FULL) begin
        next_count = count + 1'b1;
      end
    end else if (pop_i && count != '0) begin
      next_ptr = top_idx;
      next_count = count - 1'b1;
    end
  end

  // reset leaves the stack empty
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ptr <= '0;
      count <= '0;
    end else begin
      ptr <= next_ptr;
      count <= next_count;
    end
  end

  // only program counter values are stored here
  always_ff @(posedge core_clk_i) begin
    if (push_i) begin
      mem[ptr] <= push_data_i;
    end
  end

  assign top_o = mem[top_idx];
  assign full_o = (count == CNT_FULL); // depth from the parameter
endmodule

// ---- bench/pcst_top_asserts.sv ----
// Purpose: port-level property checks for pcst_top
// Assumes: single clock core_clk_i, asynchronous reset arst_n_i
// Notes: bound into every pcst_top instance after the module
module pcst_top_asserts #(
  parameter int PMEM_WORDS = 8192,
  parameter int STACK_DEPTH = 8,
  localparam int AW = $clog2(PMEM_WORDS)
) (
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input pcst_pkg::pcst_cmd_t cmd_i,
  input wire logic [15:0] int_vector_i,
  input wire logic table_high_latch_wr_i,
  input pcst_pkg::pcst_alu_req_t alu_req_i,
  input wire logic [AW-1:0] pc_o,
  input wire logic ready_o,
  input wire logic int_ack_o,
  input pcst_pkg::pcst_dwr_t dwr_o,
  input wire logic [7:0] table_high_latch_o,
  input pcst_pkg::pcst_alu_res_t alu_res_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import pcst_pkg::*;
  logic tbl;
  assign tbl = ready_o && cmd_i.op inside {[op_table_read:long_table_read_lastpage_op]};
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!arst_n_i);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  sequence s_refetch;
    !ready_o ##1 ready_o;
  endsequence
  sequence s_tbl_done;
    !ready_o && !dwr_o.wr ##1 dwr_o.wr && ready_o;
  endsequence
  property p_call;
    ready_o && cmd_i.op == op_call |=> pc_o == $past(cmd_i.target[AW-1:0]) ##0 s_refetch;
  endproperty
  a_call: assert property (p_call) else $error("call target or refetch wrong");
  property p_branch;
    ready_o && cmd_i.op inside {op_jump, subroutine_return_op, interrupt_return_op,
                                op_pcl_write} |=> s_refetch;
  endproperty
  a_branch: assert property (p_branch) else $error("branch refetch wrong");
  property p_table;
    tbl |=> s_tbl_done ##0 dwr_o.addr == $past(cmd_i.dest_addr, 2);
  endproperty
  a_table: assert property (p_table) else $error("table write timing wrong");
  property p_sector;
    tbl |-> ##2 dwr_o.sector == ($past(cmd_i.op, 2) inside {op_table_read,
      table_read_lastpage_op} ? 8'h00 : $past(cmd_i.dest_sector, 2));
  endproperty
  a_sector: assert property (p_sector) else $error("table sector wrong");
  property p_table_high_latch;
    $changed(table_high_latch_o) |-> dwr_o.wr || $past(table_high_latch_wr_i);
  endproperty
  a_table_high_latch: assert property (p_table_high_latch) else $error("latch changed without cause");
  property p_alu;
    alu_req_i.valid |=> alu_res_o.valid && alu_res_o.dest_addr == $past(alu_req_i.dest_addr);
  endproperty
  a_alu: assert property (p_alu) else $error("alu result missing");
  property p_ack;
    int_ack_o |-> pc_o == $past(int_vector_i[AW-1:0]) && $past(cmd_i.op) == op_none
      ##0 s_refetch;
  endproperty
  a_ack: assert property (p_ack) else $error("interrupt entry wrong");
  property p_reset;
    $rose(arst_n_i) |-> (pc_o == '0) [*3];
  endproperty
  a_reset: assert property (p_reset) else $error("pc not at vector after reset");
endmodule

bind pcst_top pcst_top_asserts #(.PMEM_WORDS(PMEM_WORDS), .STACK_DEPTH(STACK_DEPTH)) u_chk (
  .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .cmd_i(cmd_i),
  .int_vector_i(int_vector_i), .table_high_latch_wr_i(table_high_latch_wr_i), .alu_req_i(alu_req_i),
  .pc_o(pc_o), .ready_o(ready_o), .int_ack_o(int_ack_o),
  .dwr_o(dwr_o), .table_high_latch_o(table_high_latch_o), .alu_res_o(alu_res_o)
);

// ---- bench/pcst_seq_model.sv ----
// Purpose: instruction sequencer and serial programmer facing pcst_top
// Assumes: tasks are called by the bench one at a time
// Notes: the serial data line has a pull-up, so a released line reads high
module pcst_seq_model (
  input wire logic core_clk_i,
  input wire logic ready_i,
  input wire logic dev_data_i,
  input wire logic dev_oe_n_i,
  output pcst_pkg::pcst_cmd_t cmd_o,
  output logic prog_mode_o,
  output logic prog_serial_clock_o,
  output logic prog_serial_data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import pcst_pkg::*;
  logic own;
  logic drv;
  // wired level of the shared line
  assign prog_serial_data_o = own ? drv : (dev_oe_n_i ? 1'b1 : dev_data_i);
  initial begin
    cmd_o = '0;
    prog_mode_o = 1'b0;
    prog_serial_clock_o = 1'b0;
    own = 1'b0;
    drv = 1'b0;
  end
  // hold a command until an edge sees ready high, then release it
  task automatic issue(input pcst_op_t op, input logic [15:0] tgt, input logic [7:0] b);
    int n;
    @(posedge core_clk_i);
    #1;
    cmd_o = '{op, tgt, b, 8'h03, b};
    n = 0;
    while (ready_i !== 1'b1 && n < 50) begin
      @(posedge core_clk_i);
      #1;
      n++;
    end
    @(posedge core_clk_i);
    #1;
    // idle fields flip so nothing leans on stale values
    cmd_o = '{op_none, ~tgt, ~b, 8'hfc, ~b};
  endtask
  // one frame: direction bit, 13 address bits, 16 data bits, msb first
  task automatic frame(input logic wr, input logic [12:0] a, input logic [15:0] d,
                       output logic [15:0] q);
    logic [29:0] f;
    int i;
    f = {wr, a, d};
    q = '0;
    prog_mode_o = 1'b1;
    for (i = 0; i < 30; i++) begin
      own = wr || i < 14;
      drv = f[29 - i];
      repeat (6) @(posedge core_clk_i);
      #1;
      if (i > 13) q[29 - i] = prog_serial_data_o;
      prog_serial_clock_o = 1'b1;
      repeat (6) @(posedge core_clk_i);
      #1;
      prog_serial_clock_o = 1'b0;
    end
    repeat (6) @(posedge core_clk_i);
    #1;
    prog_mode_o = 1'b0;
    own = 1'b0;
    // mode must be seen low between frames, else the bit count never clears
    repeat (6) @(posedge core_clk_i);
    #1;
  endtask
endmodule

// ---- bench/pcst_top_test.sv ----
// Purpose: self-checking bench for pcst_top
// Assumes: pcst_seq_model plays the sequencer and the programmer
// Notes: stack depth set to the six-level variant
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin fail_count++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end

module pcst_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  import pcst_pkg::*;
  logic clk, arst_n, int_req, int_en, table_high_latch_wr, ready, ack, psclk, pmode, pdi, pdo, poe_n;
  logic [15:0] vec, instr, q;
  logic [7:0] tblp, tbhp, table_high_latch_wd, table_high_latch;
  logic [12:0] pc;
  pcst_cmd_t cmd;
  pcst_alu_req_t alu_req;
  pcst_alu_res_t alu_res;
  pcst_dwr_t dwr;
  int fail_count = 0;
  int samples_checked = 0;
  int acks = 0;
  int cycles = 0;
  pcst_top #(.PMEM_WORDS(8192), .STACK_DEPTH(6)) dut (
    .core_clk_i(clk), .arst_n_i(arst_n), .cmd_i(cmd), .int_req_i(int_req),
    .int_en_i(int_en), .int_vector_i(vec), .tblp_i(tblp), .tbhp_i(tbhp),
    .table_high_latch_wr_i(table_high_latch_wr), .table_high_latch_wdata_i(table_high_latch_wd), .alu_req_i(alu_req),
    .prog_mode_i(pmode), .prog_serial_clock_i(psclk), .prog_serial_data_i(pdi),
    .pc_o(pc), .instr_o(instr), .ready_o(ready), .int_ack_o(ack), .dwr_o(dwr),
    .table_high_latch_o(table_high_latch), .alu_res_o(alu_res), .prog_serial_data_o(pdo),
    .prog_serial_data_oe_n_o(poe_n)
  );
  pcst_seq_model sq (
    .core_clk_i(clk), .ready_i(ready), .dev_data_i(pdo), .dev_oe_n_i(poe_n),
    .cmd_o(cmd), .prog_mode_o(pmode), .prog_serial_clock_o(psclk), .prog_serial_data_o(pdi)
  );
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // a hang costs one mismatch; the full run needs about 1600 cycles
  always @(posedge clk) begin
    cycles++;
    if (ack === 1'b1) acks++;
    if (cycles == 5000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic t_stack();
    logic [12:0] rets[$];
    logic [12:0] e;
    int i;
    for (i = 0; i < 7; i++) begin
      rets.push_back(pc + 13'h1);
      sq.issue(op_call, 16'h0100 + 16'(i * 16), 8'h00);
      `CHK("call pc", 13'h0100 + 13'(i * 16), pc)
    end
    for (i = 0; i < 6; i++) begin
      e = rets.pop_back();
      sq.issue(subroutine_return_op, 16'h0000, 8'h00);
      `CHK("return pc", e, pc)
    end
  endtask
  task automatic t_int();
    int i;
    int n;
    int_en = 1'b1;
    for (i = 0; i < 6; i++) sq.issue(op_call, 16'h0100 + 16'(i * 16), 8'h00);
    n = acks;
    int_req = 1'b1;
    tick(1);
    int_req = 1'b0;
    tick(10);
    `CHK("ack while full", n, acks)
    sq.issue(subroutine_return_op, 16'h0000, 8'h00);
    tick(6);
    `CHK("ack after return", n + 1, acks)
    `CHK("vector pc", 13'h0040, pc)
    sq.issue(interrupt_return_op, 16'h0000, 8'h00);
    `CHK("interrupt return pc", 13'h0141, pc)
  endtask
  task automatic t_table();
    pcst_op_t ops[4] = '{op_table_read, table_read_lastpage_op, long_table_read_op,
                         long_table_read_lastpage_op};
    logic [12:0] p;
    int i;
    int_en = 1'b0; // interrupts off around main-line table reads
    tblp = 8'h05;
    tbhp = 8'h0a;
    for (i = 0; i < 4; i++) begin
      p = pc;
      sq.issue(ops[i], 16'h0000, 8'h20 + 8'(i));
      `CHK("table pc", p + 13'h1, pc)
      tick(1);
      `CHK("table write", 1'b1, dwr.wr)
      `CHK("table sector", (i < 2) ? 8'h00 : 8'h03, dwr.sector)
      `CHK("table low", (i % 2) ? 8'ha5 : 8'hef, dwr.data)
      `CHK("table high", (i % 2) ? 8'hc3 : 8'hbe, table_high_latch)
    end
    table_high_latch_wr = 1'b1;
    table_high_latch_wd = 8'h5a;
    tick(1);
    table_high_latch_wr = 1'b0;
    `CHK("latch write", 8'h5a, table_high_latch)
  endtask
  task automatic t_flow();
    sq.issue(op_jump, 16'h0200, 8'h00);
    `CHK("refetch", 1'b0, ready)
    sq.issue(op_pcl_write, 16'h0000, 8'h77);
    `CHK("pcl pc", 13'h0277, pc)
    sq.issue(op_seq, 16'h0000, 8'h00);
    `CHK("seq pc", 13'h0278, pc)
    `CHK("seq ready", 1'b1, ready)
  endtask
  task automatic t_alu(input pcst_alu_op_t op, input logic [7:0] a, input logic [7:0] b,
                       input logic [7:0] d, input logic c, input logic z, input logic ac);
    alu_req = '{1'b1, op, a, b, 1'b0, 1'b0, 1'b0, 1'b1, 8'h33};
    tick(1);
    `CHK("alu data", d, alu_res.data)
    `CHK("alu carry", c, alu_res.c)
    `CHK("alu zero", z, alu_res.z)
    `CHK("alu half carry", ac, alu_res.ac)
    `CHK("alu to memory", 1'b1, alu_res.to_mem)
  endtask
  task automatic t_reset();
    int n;
    sq.issue(op_call, 16'h0300, 8'h00);
    arst_n = 1'b0;
    tick(3);
    arst_n = 1'b1;
    for (n = 0; n < 10 && ready !== 1'b1; n++) tick(1);
    `CHK("reset pc", 13'h0000, pc)
    `CHK("reset word", 16'h1234, instr)
    int_en = 1'b1;
    n = acks;
    int_req = 1'b1;
    tick(1);
    int_req = 1'b0;
    tick(4);
    `CHK("ack after reset", n + 1, acks)
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    arst_n = 1'b0;
    int_req = 1'b0;
    int_en = 1'b0;
    vec = 16'h0040;
    tblp = 8'h00;
    tbhp = 8'h00;
    table_high_latch_wr = 1'b0;
    table_high_latch_wd = 8'h00;
    alu_req = '0;
    tick(16);
    arst_n = 1'b1;
    tick(4);
    sq.frame(1'b1, 13'h0000, 16'h1234, q);
    sq.frame(1'b1, 13'h0a05, 16'hbeef, q);
    sq.frame(1'b1, 13'h1f05, 16'hc3a5, q);
    sq.frame(1'b0, 13'h0a05, 16'h0000, q);
    `CHK("serial read", 16'hbeef, q)
    `CHK("line released", 1'b1, poe_n)
    t_stack();
    t_int();
    t_table();
    t_flow();
    t_alu(alu_add, 8'hf0, 8'h20, 8'h10, 1'b1, 1'b0, 1'b0);
    t_alu(alu_sub, 8'h05, 8'h05, 8'h00, 1'b1, 1'b1, 1'b1);
    t_alu(alu_xor, 8'h5a, 8'h5a, 8'h00, 1'b0, 1'b1, 1'b0);
    alu_req.valid = 1'b0;
    t_reset();
    tally_and_finish();
  end
endmodule
